// File: core/dic_pkg.sv
package dic_pkg;

  // register byte offsets, one aligned word each
  localparam logic [7:0] OFS_STATUS    = 8'h04; // controller_status_reg
  localparam logic [7:0] OFS_BANKCFG   = 8'h08; // bank_config_reg
  localparam logic [7:0] OFS_REFRESH   = 8'h0c; // refresh_control_reg
  localparam logic [7:0] OFS_TIMING1   = 8'h10; // timing_reg_one
  localparam logic [7:0] OFS_TIMING2   = 8'h14; // timing_reg_two
  localparam logic [7:0] OFS_RAWINT    = 8'h20; // raw_interrupt_reg
  localparam logic [7:0] OFS_MASKSET   = 8'h28; // interrupt_mask_set_reg
  localparam logic [7:0] OFS_MASKCLR   = 8'h2c; // mask clear
  localparam logic [7:0] OFS_IOCTRL    = 8'he4; // io_layer_control_reg
  localparam logic [7:0] OFS_CALCTRL   = 8'hf0; // calibration_control_reg
  localparam logic [7:0] OFS_CALRESULT = 8'hf4; // calibration result
  localparam logic [7:0] OFS_CALACCESS = 8'hf8; // calibration result access enable
  localparam logic [7:0] OFS_ACCESS    = 8'hfc; // access mode probe

  // field positions
  localparam int BIT_TIM_UNLOCK  = 15;  // timing_unlock_bit in bank_config_reg
  localparam int BIT_DRIVE       = 18;  // drive_strength_field
  localparam int BIT_SELF_REF    = 31;  // self_refresh_bit
  localparam int BIT_CLK_STOP_EN = 30;  // memory_clock_stop_enable
  localparam int BIT_DLL_PD      = 4;   // dll_power_down_bit
  localparam int BIT_CAL_EN      = 13;  // calibration enable
  localparam int BIT_RECALIBRATE_BIT       = 15;  // recalibrate_bit
  localparam int BIT_IO_READY    = 2;   // io_layer_ready_flag
  localparam int BIT_INIT_DONE   = 0;   // status: init finished
  localparam int BIT_CAL_DONE    = 1;   // status: calibration finished
  localparam int BIT_LINE_TRAP   = 2;   // line_trap_flag

  // reset values
  localparam logic [31:0] RST_BANKCFG = 32'h0000_0000;
  localparam logic [31:0] RST_REFRESH = 32'h0000_0000;
  localparam logic [31:0] RST_TIMING  = 32'h0000_0000;
  localparam logic [31:0] RST_IOCTRL  = 32'h0000_0000;
  localparam logic [31:0] RST_CALCTRL = 32'h0000_0000;

  // timing
  localparam int CLK_MHZ       = 50;
  localparam int INIT_CYCLES   = 64;  // init sequence length
  localparam int CAL_CLK_COUNT = 33;  // calibration clock edges to finish
  localparam int DLL_CYCLES    = 16;  // dll lock time
  localparam int DRAIN_CYCLES  = 8;   // outstanding work drain time

  // access burst modes
  localparam logic [1:0] MODE_LINEAR = 2'h0;
  localparam logic [1:0] MODE_WRAP   = 2'h1;

  typedef struct packed {
    logic [11:0] pAddr;
    logic        pWrite;
    logic [31:0] pWdata;
  } dic_apb_req_t;

  typedef enum {ST_INIT, ST_IDLE, ST_DRAIN, ST_SELFREF, ST_WAKE} dic_pwr_t;

endpackage

// File: core/dic_ctrl.sv
`timescale 1ns/1ps
// Functional notes
// - init restarts on reset or bank config write
// - recalibrate_bit write with calibration enable set starts calibration
// - access enable gates result readability
// - enable low stops calibration
// - accesses stall until calibration completes
// - unsupported mode sets line trap flag
// - unsupported mode served as linear
// - interrupt only when mask enabled
// - self refresh after draining work
// - clock stop enable permits clock off
// - dll power down bit powers dll down in self refresh
// - ready low when clock stopped or dll down, else high
// - access wakes dll and clock together, then serves after dll lock time
// - debug halt does not stop operation
module dic_ctrl
  import dic_pkg::*;
#(
  parameter int CAL_CODE_W = 5
)(
  // system
  input  wire logic        clock,
  input  wire logic        srst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // calibration clock, sampled as a pin
  input  wire logic        calClock,
  // measured impedance codes
  input  wire logic [CAL_CODE_W-1:0] pCodeIn,
  input  wire logic [CAL_CODE_W-1:0] nCodeIn,
  // memory-side status
  output logic             memClockEn,
  output logic             dllPowerDown,
  output logic             selfRefresh,
  output logic             lineTrapIrq
);
  import dic_pkg::*;

  // elaboration guard: both codes together must fit one bus word
  if (CAL_CODE_W < 1 || CAL_CODE_W > 12)
  begin
    $error("CAL_CODE_W out of range");
  end

  // register storage
  logic [31:0] bankCfg_r;           // bank_config_reg
  logic [31:0] refresh_r;           // refresh_control_reg
  logic [31:0] timing1_r;           // timing_reg_one
  logic [31:0] timing2_r;           // timing_reg_two
  logic [31:0] ioCtrl_r;            // io_layer_control_reg
  logic [31:0] calCtrl_r;           // calibration_control_reg
  logic        calAccess_r;         // result readability
  logic        lineTrap_r;          // line_trap_flag
  logic        lineMask_r;          // mask for line trap
  logic [2*CAL_CODE_W-1:0] calResult_r; // captured codes

  // apb decode
  dic_apb_req_t req;
  logic         wrEn;
  logic         accessPhase;
  assign req         = '{pAddr: paddr, pWrite: pwrite, pWdata: pwdata};
  assign accessPhase = psel && penable;
  assign wrEn        = accessPhase && pready && req.pWrite;

  function automatic logic hit(input logic [11:0] a, input logic [7:0] ofs);
    hit = (a == {4'h0, ofs});
  endfunction

  // power state and counters
  dic_pwr_t    pwr_r;
  logic [7:0]  cnt_r;
  logic        initDone_r;
  logic        calDone_r;
  logic        calRun_r;
  logic [5:0]  calEdges_r;
  logic        calSync1_r, calSync2_r, calSync3_r;
  logic        calEdge;
  logic        wakeReq_r;
  logic [2*CAL_CODE_W-1:0] codeSync1_r, codeSync2_r; // measured codes, two-stage sync

  // calibration clock and codes sampled twice; edges found after sync
  always_ff @(posedge clock)
  begin
    calSync1_r  <= calClock;
    calSync2_r  <= calSync1_r;
    calSync3_r  <= calSync2_r;
    codeSync1_r <= {pCodeIn, nCodeIn};
    codeSync2_r <= codeSync1_r;
  end
  assign calEdge = calSync2_r && !calSync3_r;

  // access probe: writes to access offset model a memory request
  logic accessReq;
  logic unsupMode;
  logic accessPend;                                        // probe waiting in access phase
  assign accessPend = accessPhase && hit(paddr, OFS_ACCESS);
  assign accessReq  = wrEn && hit(req.pAddr, OFS_ACCESS);
  assign unsupMode = (req.pWdata[1:0] != MODE_LINEAR) && (req.pWdata[1:0] != MODE_WRAP);

  // accesses stall while uncalibrated, waking, or initializing
  logic accessBlocked;
  assign accessBlocked = !calDone_r || (pwr_r != ST_IDLE);

  // apb ready: access probe waits for block to be served
  always_comb
  begin
    pready = 1'b1;
    if (accessPend && accessBlocked)
      pready = 1'b0;
  end
  assign pslverr = 1'b0;

  // configuration registers
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      bankCfg_r <= RST_BANKCFG;
      refresh_r <= RST_REFRESH;
      timing1_r <= RST_TIMING;
      timing2_r <= RST_TIMING;
      ioCtrl_r  <= RST_IOCTRL;
    end
    else if (wrEn)
    begin
      if (hit(req.pAddr, OFS_BANKCFG))
        bankCfg_r <= req.pWdata;
      if (hit(req.pAddr, OFS_REFRESH))
        refresh_r <= req.pWdata;
      if (hit(req.pAddr, OFS_TIMING1) && bankCfg_r[BIT_TIM_UNLOCK])
        timing1_r <= req.pWdata;
      if (hit(req.pAddr, OFS_TIMING2) && bankCfg_r[BIT_TIM_UNLOCK])
        timing2_r <= req.pWdata;
      if (hit(req.pAddr, OFS_IOCTRL))
        ioCtrl_r <= req.pWdata;
    end
  end

  // calibration control and result access
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      calCtrl_r   <= RST_CALCTRL;
      calAccess_r <= 1'b0;
    end
    else if (wrEn)
    begin
      if (hit(req.pAddr, OFS_CALCTRL))
        calCtrl_r <= req.pWdata;
      if (hit(req.pAddr, OFS_CALACCESS))
        calAccess_r <= req.pWdata[0];
    end
  end

  // calibration run: starts on recalibrate_bit write with enable, counts edges
  logic calStart;
  assign calStart = wrEn && hit(req.pAddr, OFS_CALCTRL) && req.pWdata[BIT_CAL_EN]
                    && req.pWdata[BIT_RECALIBRATE_BIT] && !calCtrl_r[BIT_RECALIBRATE_BIT];
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      calRun_r    <= 1'b0;
      calDone_r   <= 1'b0;
      calEdges_r  <= '0;
      calResult_r <= '0;
    end
    else if (calStart)
    begin
      calRun_r   <= 1'b1;
      calDone_r  <= 1'b0;
      calEdges_r <= '0;
    end
    else if (calRun_r)
    begin
      if (!calCtrl_r[BIT_CAL_EN])
        calRun_r <= 1'b0;
      else if (calEdge)
      begin
        if (calEdges_r == 6'(CAL_CLK_COUNT - 1))
        begin
          calRun_r    <= 1'b0;
          calDone_r   <= 1'b1;
          calResult_r <= codeSync2_r;
        end
        calEdges_r <= calEdges_r + 6'h01;
      end
    end
  end

  // line trap flag: set wins over clear
  logic trapClr;
  assign trapClr = wrEn && hit(req.pAddr, OFS_RAWINT) && req.pWdata[BIT_LINE_TRAP];
  always_ff @(posedge clock)
  begin
    if (srst)
      lineTrap_r <= 1'b0;
    else if (accessReq && pready && unsupMode)
      lineTrap_r <= 1'b1;
    else if (trapClr)
      lineTrap_r <= 1'b0;
  end

  // mask set and clear registers
  always_ff @(posedge clock)
  begin
    if (srst)
      lineMask_r <= 1'b0;
    else if (wrEn && hit(req.pAddr, OFS_MASKSET) && req.pWdata[BIT_LINE_TRAP])
      lineMask_r <= 1'b1;
    else if (wrEn && hit(req.pAddr, OFS_MASKCLR) && req.pWdata[BIT_LINE_TRAP])
      lineMask_r <= 1'b0;
  end
  assign lineTrapIrq = lineTrap_r && lineMask_r;

  // init retrigger: reset or any write to bank config
  logic initKick;
  assign initKick = wrEn && hit(req.pAddr, OFS_BANKCFG);

  // power/initialization state machine; debug halt has no input so never stops it
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      pwr_r      <= ST_INIT;
      cnt_r      <= '0;
      initDone_r <= 1'b0;
      wakeReq_r  <= 1'b0;
    end
    else if (initKick)
    begin
      pwr_r      <= ST_INIT;
      cnt_r      <= '0;
      initDone_r <= 1'b0;
    end
    else
    begin
      // a stalled probe never completes while asleep, so its pending phase must wake us
      if (accessPend)
        wakeReq_r <= 1'b1;
      case (pwr_r)
        ST_INIT:
        begin
          cnt_r <= cnt_r + 8'h01;
          if (cnt_r == 8'(INIT_CYCLES - 1))
          begin
            pwr_r      <= ST_IDLE;
            initDone_r <= 1'b1;
            cnt_r      <= '0;
          end
        end
        ST_IDLE:
        begin
          wakeReq_r <= 1'b0;
          if (refresh_r[BIT_SELF_REF])
          begin
            pwr_r <= ST_DRAIN;
            cnt_r <= '0;
          end
        end
        ST_DRAIN:
        begin
          cnt_r <= cnt_r + 8'h01;
          if (cnt_r == 8'(DRAIN_CYCLES - 1))
            pwr_r <= ST_SELFREF;
        end
        ST_SELFREF:
        begin
          cnt_r <= '0;
          if (wakeReq_r || accessPend || !refresh_r[BIT_SELF_REF])
            pwr_r <= ST_WAKE;
        end
        ST_WAKE:
        begin
          cnt_r <= cnt_r + 8'h01;
          if (cnt_r == 8'(DLL_CYCLES - 1))
          begin
            pwr_r     <= ST_IDLE;
            wakeReq_r <= 1'b0;
          end
        end
        default:
          pwr_r <= ST_INIT;
      endcase
    end
  end

  // memory clock and dll outputs
  logic stopped;
  assign stopped      = (pwr_r == ST_SELFREF);
  assign selfRefresh  = stopped;
  assign memClockEn   = !(stopped && refresh_r[BIT_CLK_STOP_EN]);
  assign dllPowerDown = stopped && ioCtrl_r[BIT_DLL_PD];

  // read mux
  always_ff @(posedge clock)
  begin
    if (srst)
      prdata <= '0;
    else if (psel && !penable && !pwrite)
    begin
      prdata <= '0;
      if (hit(paddr, OFS_STATUS))
        prdata <= {29'h0, memClockEn && !dllPowerDown, calDone_r, initDone_r};
      if (hit(paddr, OFS_BANKCFG))
        prdata <= bankCfg_r;
      if (hit(paddr, OFS_REFRESH))
        prdata <= refresh_r;
      if (hit(paddr, OFS_TIMING1))
        prdata <= timing1_r;
      if (hit(paddr, OFS_TIMING2))
        prdata <= timing2_r;
      if (hit(paddr, OFS_IOCTRL))
        prdata <= ioCtrl_r;
      if (hit(paddr, OFS_CALCTRL))
        prdata <= calCtrl_r;
      if (hit(paddr, OFS_RAWINT))
        prdata <= {29'h0, lineTrap_r, 2'h0};
      if (hit(paddr, OFS_MASKSET) || hit(paddr, OFS_MASKCLR))
        prdata <= {29'h0, lineMask_r, 2'h0};
      if (hit(paddr, OFS_CALRESULT) && calAccess_r)
        prdata <= 32'(calResult_r);
    end
  end

  // assertions
  a_timing_locked: assert property (@(posedge clock) disable iff (srst)
    (wrEn && hit(req.pAddr, OFS_TIMING1) && !bankCfg_r[BIT_TIM_UNLOCK])
      |=> $stable(timing1_r)) else $error("timing written while locked");
  a_trap_sets: assert property (@(posedge clock) disable iff (srst)
    (accessReq && pready && unsupMode) |=> lineTrap_r) else $error("line trap missed");
  a_irq_masked: assert property (@(posedge clock) disable iff (srst)
    lineTrapIrq |-> lineMask_r) else $error("irq unmasked");
  a_irq_follows: assert property (@(posedge clock) disable iff (srst)
    (wrEn && hit(req.pAddr, OFS_MASKSET) && req.pWdata[BIT_LINE_TRAP] && lineTrap_r)
      |=> lineTrapIrq) else $error("irq not raised by mask");
  a_access_stall: assert property (@(posedge clock) disable iff (srst)
    (accessPhase && hit(paddr, OFS_ACCESS) && !calDone_r) |-> !pready)
    else $error("access done uncalibrated");
  a_init_kick: assert property (@(posedge clock) disable iff (srst)
    initKick |=> (pwr_r == ST_INIT) && !initDone_r) else $error("init not restarted");
  a_cal_start: assert property (@(posedge clock) disable iff (srst)
    calStart |=> calRun_r && !calDone_r) else $error("calibration not started");
  a_dll_down: assert property (@(posedge clock) disable iff (srst)
    (pwr_r == ST_DRAIN && cnt_r == 8'(DRAIN_CYCLES - 1) && ioCtrl_r[BIT_DLL_PD] && !wrEn)
      |=> dllPowerDown) else $error("dll still up");
  // wake: dll lock time spent in the wake state, then idle to serve the access
  sequence s_wake_run;
    (pwr_r == ST_WAKE) ##16 (pwr_r == ST_IDLE);
  endsequence
  a_wake_path: assert property (@(posedge clock) disable iff (srst)
    (stopped && accessPend) |=> s_wake_run) else $error("no wake on access");
endmodule

// File: bench/dic_cal_model.sv
`timescale 1ns/1ps
// calibration source: a clock pin and the measured impedance codes
module dic_cal_model
#(
  parameter int                CODE_W = 5,
  parameter logic [CODE_W-1:0] P_CODE = 5'h15, // arbitrary test code
  parameter logic [CODE_W-1:0] N_CODE = 5'h0a  // arbitrary test code
)(
  // switch from software
  input  wire logic              clkOn,
  // pins toward the controller
  output logic                   calClock,
  output logic [CODE_W-1:0]      pCode,
  output logic [CODE_W-1:0]      nCode
);
  // 160 ns period; stands low while switched off, so no stray edges count
  initial calClock = 1'b0;
  always #80 calClock = clkOn ? ~calClock : 1'b0;
  // codes are levels held by the measuring cells
  assign pCode = P_CODE;
  assign nCode = N_CODE;
endmodule

// File: bench/ddr2_ctrl_init_power_mgmt_test.sv
`timescale 1ns/1ps
module ddr2_ctrl_init_power_mgmt_test;
  import dic_pkg::*;
  // bus and pins
  logic        clock = 1'b0;
  logic        srst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic        pready, pslverr, calClock, memClockEn, dllPowerDown, selfRefresh, lineTrapIrq;
  logic        calOn = 1'b0;  // calibration clock switch
  logic [4:0]  pCode, nCode;
  // bench state
  logic [31:0] rd;            // last read data
  logic        ok;            // last wait saw pready
  int          nMismatch = 0;
  int          samplesChecked = 0;

  // 50 MHz clock
  always #10 clock = ~clock;

  dic_ctrl dut (.clock(clock), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .calClock(calClock), .pCodeIn(pCode), .nCodeIn(nCode), .memClockEn(memClockEn),
    .dllPowerDown(dllPowerDown), .selfRefresh(selfRefresh), .lineTrapIrq(lineTrapIrq));

  dic_cal_model cal (.clkOn(calOn), .calClock(calClock), .pCode(pCode), .nCode(nCode));

  task check(input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp)
    begin
      nMismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task finish_test;
    $display("checks %0d mismatches %0d", samplesChecked, nMismatch);
    if (nMismatch == 0 && samplesChecked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // two-cycle synchronous reset; also drops any stuck request
  task do_reset;
    @(posedge clock);
    srst <= 1'b1;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
  endtask

  // setup cycle, then raise penable
  task automatic setup(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {4'h0, a};
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
  endtask

  // hold the request until pready is seen at an edge, bounded
  task automatic wait_rdy(input int lim);
    int n;
    n = 0;
    ok = 1'b0;
    while (!ok && n < lim)
    begin
      @(posedge clock);
      n++;
      ok = (pready === 1'b1);
    end
  endtask

  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    setup(a, w, d);
    wait_rdy(2000);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (!ok)
      nMismatch++;
  endtask

  // poll one status bit, bounded
  task automatic poll(input int b, input logic v);
    int n;
    n = 0;
    apb(OFS_STATUS, 1'b0, '0);
    while (rd[b] !== v && n < 500)
    begin
      apb(OFS_STATUS, 1'b0, '0);
      n++;
    end
  endtask

  // after reset with the calibration clock off, probes never finish
  task t_stall;
    setup(OFS_ACCESS, 1'b1, 32'h0);
    wait_rdy(100);
    check(ok, 1'b0);
  endtask

  // init restart and timing lock
  task t_cfg;
    check(pready, 1'b1);
    check(prdata, 32'h0);
    poll(BIT_INIT_DONE, 1'b1);
    check(rd[BIT_INIT_DONE], 1'b1);
    apb(OFS_IOCTRL, 1'b1, 32'h0000_0005);
    apb(OFS_TIMING1, 1'b1, 32'h1234_5678);
    apb(OFS_TIMING1, 1'b0, '0);
    check(rd, RST_TIMING);
    check(pslverr, 1'b0);
    apb(OFS_BANKCFG, 1'b1, 32'h0000_8432);
    apb(OFS_STATUS, 1'b0, '0);
    check(rd[BIT_INIT_DONE], 1'b0);
    poll(BIT_INIT_DONE, 1'b1);
    apb(OFS_TIMING1, 1'b1, 32'h1234_5678);
    apb(OFS_TIMING2, 1'b1, 32'h0000_9abc);
    apb(OFS_TIMING2, 1'b0, '0);
    check(rd, 32'h0000_9abc);
    apb(OFS_BANKCFG, 1'b1, 32'h0000_0432);
    apb(OFS_TIMING1, 1'b1, 32'h0);
    apb(OFS_TIMING1, 1'b0, '0);
    check(rd, 32'h1234_5678);
    apb(OFS_REFRESH, 1'b1, 32'h0000_040e);
    poll(BIT_INIT_DONE, 1'b1);
    do_reset();
  endtask

  // impedance calibration handshake
  task t_cal;
    calOn <= 1'b1;
    apb(OFS_CALCTRL, 1'b1, 32'h0000_201f);
    apb(OFS_CALCTRL, 1'b1, 32'h0000_a01f);
    apb(OFS_STATUS, 1'b0, '0);
    check(rd[BIT_CAL_DONE], 1'b0);
    poll(BIT_CAL_DONE, 1'b1);
    check(rd[BIT_CAL_DONE], 1'b1);
    apb(OFS_CALRESULT, 1'b0, '0);
    check(rd, 32'h0);
    apb(OFS_CALACCESS, 1'b1, 32'h1);
    apb(OFS_CALRESULT, 1'b0, '0);
    check(rd, {22'h0, 5'h15, 5'h0a});
    apb(OFS_CALCTRL, 1'b1, 32'h0000_a01f);
    apb(OFS_CALCTRL, 1'b1, 32'h0000_801f);
    apb(OFS_CALACCESS, 1'b1, 32'h0);
    apb(OFS_CALRESULT, 1'b0, '0);
    check(rd, 32'h0);
    calOn <= 1'b0;
  endtask

  // every access mode; trap flag, mask and clear
  task t_trap;
    for (int m = 0; m < 4; m++)
    begin
      apb(OFS_ACCESS, 1'b1, m);
      check(ok, 1'b1);
      apb(OFS_RAWINT, 1'b0, '0);
      check(rd[BIT_LINE_TRAP], m > 1);
      check(lineTrapIrq, 1'b0);
      apb(OFS_RAWINT, 1'b1, 32'h4);
    end
    apb(OFS_ACCESS, 1'b1, 32'h2);
    apb(OFS_MASKSET, 1'b1, 32'h4);
    apb(OFS_RAWINT, 1'b0, '0);
    check(lineTrapIrq, 1'b1);
    apb(OFS_RAWINT, 1'b1, 32'h4);
    apb(OFS_RAWINT, 1'b0, '0);
    check(lineTrapIrq, 1'b0);
  endtask

  // self-refresh, clock stop, dll off, wake on access, restore
  task t_power;
    apb(OFS_REFRESH, 1'b1, 32'hc000_040e);
    check(selfRefresh, 1'b0);
    apb(OFS_IOCTRL, 1'b1, 32'h0000_0015);
    poll(BIT_IO_READY, 1'b0);
    check(rd[BIT_IO_READY], 1'b0);
    check(selfRefresh, 1'b1);
    check(memClockEn, 1'b0);
    check(dllPowerDown, 1'b1);
    apb(OFS_ACCESS, 1'b1, 32'h0);
    check(ok, 1'b1);
    apb(OFS_REFRESH, 1'b1, 32'h0000_040e);
    apb(OFS_IOCTRL, 1'b1, 32'h0000_0005);
    poll(BIT_IO_READY, 1'b1);
    check(rd[BIT_IO_READY], 1'b1);
    check(memClockEn, 1'b1);
    check(dllPowerDown, 1'b0);
    do_reset();
  endtask

  // a hang ends here as a mismatch
  initial
  begin
    #400000;
    nMismatch++;
    finish_test();
  end

  initial
  begin
    do_reset();
    t_stall();
    do_reset();
    t_cfg();
    t_cal();
    t_trap();
    t_power();
    t_stall();
    finish_test();
  end
endmodule
